/* File: design/phase_selective_trip_logic.sv */
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - mode setting: off, three-phase only, single-or-three; off after reset.
// - in off mode no trip output is ever driven.
// - minimum pulse setting 50 to 60000 ms, 1 ms step, default 150.
// - an asserted trip stays asserted at least the minimum pulse length unless blocked or set to off.
// - evolving fault wait setting 50 to 60000 ms, default 1000.
// - a new request during the evolving wait trips all three phases.
// - two phase starts also trip the third phase.
// - force input turns any trip into a three-phase trip.
// - reclosing can demand three-phase trip for a single-phase fault.
// - block input holds every trip output inactive.
// - one trip output per phase.
// - general trip output active for any trip.
// - three-phase indicator active when all three phases trip.
module phase_selective_trip_logic (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic trip_output_block_in,
	input wire logic single_phase_request_in,
	input wire logic three_phase_request_in,
	input wire logic phase_a_start_in,
	input wire logic phase_b_start_in,
	input wire logic phase_c_start_in,
	input wire logic force_all_phases_in,
	output logic phase_a_trip_out,
	output logic phase_b_trip_out,
	output logic phase_c_trip_out,
	output logic any_trip_out,
	output logic all_phase_trip_out,
	output logic irq_out,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TRIP = 3'b010,
		ST_EVOLVE = 3'b100
	} state_t;

	trip_logic_pkg::request_t req;
	trip_logic_pkg::phases_t raw;
	trip_logic_pkg::phases_t held;
	trip_logic_pkg::phases_t next_held;
	state_t state;
	state_t next_state;
	logic [1:0] mode;
	logic [15:0] pulse_ms;
	logic [15:0] evolve_ms;
	logic [15:0] ms_count;
	logic [16:0] tick_div;
	logic tick;
	logic want;
	logic three_ph;
	logic two_starts;
	logic enabled;
	logic [trip_logic_pkg::IRQ_BITS-1:0] irq_status;
	logic [trip_logic_pkg::IRQ_BITS-1:0] irq_mask;
	logic [trip_logic_pkg::IRQ_BITS-1:0] irq_event;
	logic wr;
	logic rd_ok;
	logic [31:0] rd_word;
	logic prev_any;
	logic prev_all;
	logic evolve_hit;

	assign req = '{block: trip_output_block_in, single: single_phase_request_in,
		three: three_phase_request_in, force_all: force_all_phases_in,
		start: '{a: phase_a_start_in, b: phase_b_start_in, c: phase_c_start_in}};

	assign enabled = (mode != trip_logic_pkg::MODE_OFF) && !req.block;
	assign want = req.three || (req.single && (req.start != 3'h0));
	assign two_starts = (req.start.a && req.start.b) || (req.start.a && req.start.c)
		|| (req.start.b && req.start.c);
	// force input is how reclosing demands a three-phase trip
	assign three_ph = req.three || req.force_all || two_starts
		|| (mode == trip_logic_pkg::MODE_THREE)
		|| (state == ST_EVOLVE);

	always_comb begin
		raw = 3'h0;
		if (enabled && want) begin
			raw = three_ph ? 3'h7 : req.start;
		end
	end

	// millisecond tick from the system clock
	// 17 bits: one millisecond is more cycles than 16 bits can count
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tick_div <= 17'h00000;
		end else if (tick_div == 17'(trip_logic_pkg::MS_CYCLES - 1)) begin
			tick_div <= 17'h00000;
		end else begin
			tick_div <= tick_div + 17'h00001;
		end
	end
	assign tick = (tick_div == 17'(trip_logic_pkg::MS_CYCLES - 1));

	always_comb begin
		next_state = state;
		next_held = held;
		case (state)
			ST_IDLE: begin
				if (raw != 3'h0) begin
					next_state = ST_TRIP;
					next_held = raw;
				end
			end
			ST_TRIP: begin
				next_held = held | raw;
				if (raw == 3'h0 && ms_count >= pulse_ms) begin
					next_state = ST_EVOLVE;
					next_held = 3'h0;
				end
			end
			ST_EVOLVE: begin
				if (raw != 3'h0) begin
					next_state = ST_TRIP;
					next_held = raw;
				end else if (ms_count >= evolve_ms) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_held = 3'h0;
			end
		endcase
		if (!enabled) begin
			// off or blocked cancels even a running minimum pulse
			next_state = ST_IDLE;
			next_held = 3'h0;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			held <= 3'h0;
		end else begin
			state <= next_state;
			held <= next_held;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ms_count <= 16'h0000;
		end else if (next_state != state) begin
			ms_count <= 16'h0000;
		end else if (tick && ms_count != 16'hFFFF) begin
			ms_count <= ms_count + 16'h0001;
		end
	end

	// outputs straight from flops; held is cleared whenever disabled
	assign phase_a_trip_out = held.a;
	assign phase_b_trip_out = held.b;
	assign phase_c_trip_out = held.c;
	assign any_trip_out = held != 3'h0;
	assign all_phase_trip_out = held == 3'h7;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;

	function automatic logic [15:0] clamp_ms(input logic [31:0] v);
		logic [15:0] r;
		r = v[15:0];
		if (v[31:16] != 16'h0000 || r > trip_logic_pkg::TIME_MS_MAX) begin
			r = trip_logic_pkg::TIME_MS_MAX;
		end else if (r < trip_logic_pkg::TIME_MS_MIN) begin
			r = trip_logic_pkg::TIME_MS_MIN;
		end
		return r;
	endfunction

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode <= trip_logic_pkg::MODE_OFF;
			pulse_ms <= trip_logic_pkg::PULSE_MS_DEFAULT;
			evolve_ms <= trip_logic_pkg::EVOLVE_MS_DEFAULT;
			irq_mask <= '0;
		end else if (wr) begin
			case (paddr)
				trip_logic_pkg::ADDR_MODE: begin
					if (pwdata[1:0] != 2'h3) begin
						mode <= pwdata[1:0];
					end
				end
				trip_logic_pkg::ADDR_PULSE: pulse_ms <= clamp_ms(pwdata);
				trip_logic_pkg::ADDR_EVOLVE: evolve_ms <= clamp_ms(pwdata);
				trip_logic_pkg::ADDR_MASK: irq_mask <= pwdata[trip_logic_pkg::IRQ_BITS-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_any <= 1'b0;
			prev_all <= 1'b0;
		end else begin
			prev_any <= next_held != 3'h0;
			prev_all <= next_held == 3'h7;
		end
	end
	assign evolve_hit = (state == ST_EVOLVE) && (next_state == ST_TRIP);
	assign irq_event[trip_logic_pkg::IRQ_TRIP] = (next_held != 3'h0) && !prev_any;
	assign irq_event[trip_logic_pkg::IRQ_ALL] = (next_held == 3'h7) && !prev_all;
	assign irq_event[trip_logic_pkg::IRQ_EVOLVE] = evolve_hit;

	genvar gi;
	generate
		for (gi = 0; gi < trip_logic_pkg::IRQ_BITS; gi++) begin : g_irq
			// set beats a clear in the same cycle
			always_ff @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					irq_status[gi] <= 1'b0;
				end else if (irq_event[gi]) begin
					irq_status[gi] <= 1'b1;
				end else if (wr && paddr == trip_logic_pkg::ADDR_IRQ && pwdata[gi]) begin
					irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate
	assign irq_out = |(irq_status & irq_mask);

	always_comb begin
		rd_ok = 1'b1;
		rd_word = 32'h00000000;
		case (paddr)
			trip_logic_pkg::ADDR_MODE: rd_word[1:0] = mode;
			trip_logic_pkg::ADDR_PULSE: rd_word[15:0] = pulse_ms;
			trip_logic_pkg::ADDR_EVOLVE: rd_word[15:0] = evolve_ms;
			trip_logic_pkg::ADDR_STATUS: rd_word[5:0] = {state == ST_EVOLVE,
				all_phase_trip_out, any_trip_out, held.c, held.b, held.a};
			trip_logic_pkg::ADDR_IRQ: rd_word[trip_logic_pkg::IRQ_BITS-1:0] = irq_status;
			trip_logic_pkg::ADDR_MASK: rd_word[trip_logic_pkg::IRQ_BITS-1:0] = irq_mask;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_word;
		end
	end
	assign pslverr = psel && penable && !rd_ok;

	a_off_no_trip: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(mode == trip_logic_pkg::MODE_OFF) |=> !any_trip_out)
		else $error("trip output while mode off");
	a_block_no_trip: assert property (@(posedge clock_in) disable iff (!resetn_in)
		trip_output_block_in |=> !any_trip_out)
		else $error("trip output while blocked");
	a_pulse_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$fell(any_trip_out) |-> $past(ms_count) >= pulse_ms || !$past(enabled))
		else $error("trip pulse shorter than minimum");
	a_two_phase_all: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(enabled && want && two_starts) |=> all_phase_trip_out)
		else $error("two-phase fault did not trip three");
	a_force_all: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(enabled && want && req.force_all) |=> all_phase_trip_out)
		else $error("forced trip not three-phase");
	sequence s_evolve_req;
		state == ST_EVOLVE && enabled && want;
	endsequence
	a_evolve_all: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_evolve_req |=> all_phase_trip_out)
		else $error("evolving fault not three-phase");
	a_mode_three: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(enabled && want && mode == trip_logic_pkg::MODE_THREE) |=> all_phase_trip_out)
		else $error("three-phase mode tripped one phase");
	a_general_trip: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(enabled && want) |=> any_trip_out)
		else $error("request gave no general trip");
	a_default_time: assert property (@(posedge clock_in)
		$rose(resetn_in) |-> pulse_ms == trip_logic_pkg::PULSE_MS_DEFAULT
		&& evolve_ms == trip_logic_pkg::EVOLVE_MS_DEFAULT)
		else $error("time settings not at default after reset");

	// a running minimum pulse never drops a phase unless blocked or set to off
	sequence s_trip_hold;
		state == ST_TRIP && enabled && (raw != 3'h0 || ms_count < pulse_ms);
	endsequence
	a_pulse_running: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_trip_hold |=> any_trip_out)
		else $error("trip dropped inside minimum pulse");
	a_held_accumulate: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_trip_hold |=> (held & $past(held)) == $past(held))
		else $error("phase dropped while tripping");
	sequence s_pulse_done;
		state == ST_TRIP && enabled && raw == 3'h0 && ms_count >= pulse_ms;
	endsequence
	a_pulse_to_evolve: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_pulse_done |=> state == ST_EVOLVE && !any_trip_out)
		else $error("finished pulse did not open evolve window");
	a_evolve_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_evolve_req |=> irq_status[trip_logic_pkg::IRQ_EVOLVE])
		else $error("evolving retrip not flagged");
	a_phase_select: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == ST_IDLE && enabled && want && !three_ph) |=> held == $past(req.start))
		else $error("select mode tripped wrong phases");
	a_three_indicator: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(enabled && want && three_ph) |=> all_phase_trip_out)
		else $error("three-phase trip without indicator");
	a_trip_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == ST_IDLE && enabled && want) |=> irq_status[trip_logic_pkg::IRQ_TRIP])
		else $error("trip start not flagged");
	a_idle_quiet: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == ST_IDLE) |-> !any_trip_out)
		else $error("trip output while idle");
	a_evolve_quiet: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == ST_EVOLVE) |-> !any_trip_out)
		else $error("trip output inside evolve window");
	a_mode_legal: assert property (@(posedge clock_in) disable iff (!resetn_in)
		mode != 2'h3)
		else $error("mode holds an unused code");
	a_mode_reset: assert property (@(posedge clock_in)
		$rose(resetn_in) |-> mode == trip_logic_pkg::MODE_OFF)
		else $error("mode not off after reset");
	a_pulse_range: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pulse_ms >= trip_logic_pkg::TIME_MS_MIN && pulse_ms <= trip_logic_pkg::TIME_MS_MAX)
		else $error("pulse setting out of range");
	a_evolve_range: assert property (@(posedge clock_in) disable iff (!resetn_in)
		evolve_ms >= trip_logic_pkg::TIME_MS_MIN && evolve_ms <= trip_logic_pkg::TIME_MS_MAX)
		else $error("evolve setting out of range");
	a_tick_bound: assert property (@(posedge clock_in) disable iff (!resetn_in)
		tick_div <= 17'(trip_logic_pkg::MS_CYCLES - 1))
		else $error("millisecond divider past its end");
endmodule

/* File: inc/trip_logic_pkg.sv */
package trip_logic_pkg;
	localparam int CLOCK_HZ = 100000000;
	localparam int MS_CYCLES = CLOCK_HZ / 1000;
	localparam logic [15:0] PULSE_MS_DEFAULT = 16'h0096;
	localparam logic [15:0] EVOLVE_MS_DEFAULT = 16'h03E8;
	localparam logic [15:0] TIME_MS_MIN = 16'h0032;
	localparam logic [15:0] TIME_MS_MAX = 16'hEA60;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_THREE = 2'h1;
	localparam logic [1:0] MODE_SELECT = 2'h2;
	localparam logic [11:0] ADDR_MODE = 12'h000;
	localparam logic [11:0] ADDR_PULSE = 12'h004;
	localparam logic [11:0] ADDR_EVOLVE = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_IRQ = 12'h010;
	localparam logic [11:0] ADDR_MASK = 12'h014;
	localparam int IRQ_BITS = 3;
	localparam int IRQ_TRIP = 0;
	localparam int IRQ_ALL = 1;
	localparam int IRQ_EVOLVE = 2;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} phases_t;

	typedef struct packed {
		logic block;
		logic single;
		logic three;
		logic force_all;
		phases_t start;
	} request_t;
endpackage

/* File: verif/prot_source.sv */
`timescale 1ns/10ps
module prot_source (
	input wire logic clock_in,
	input wire logic [1:0] kind_in,
	input wire trip_logic_pkg::phases_t fault_in,
	input wire logic block_in,
	input wire logic force_in,
	output trip_logic_pkg::request_t req_out
);
	// kind: 0 idle, 1 single-phase, 2 three-phase
	always @(posedge clock_in) begin
		req_out.block <= block_in;
		req_out.force_all <= force_in;
		req_out.single <= kind_in == 2'h1;
		req_out.three <= kind_in == 2'h2;
		// starts ride along any nonzero kind, including 3 which raises no request, and are cleared for kind 0
		req_out.start <= (kind_in != 2'h0) ? fault_in : 3'h0;
	end
endmodule

/* File: verif/tb_phase_selective_trip_logic.sv */
`timescale 1ns/10ps
module tb_phase_selective_trip_logic;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [2:0] fault = 3'h0;
	logic blk = 1'b0;
	logic frc = 1'b0;
	trip_logic_pkg::request_t req;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pa, pb, pc, any, all, irq;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int compares = 0;
	wire logic [4:0] trips = {pa, pb, pc, any, all};

	initial begin
		forever #5 clock_in = ~clock_in;
	end

	prot_source SRC (.clock_in(clock_in), .kind_in(kind), .fault_in(fault),
		.block_in(blk), .force_in(frc), .req_out(req));

	phase_selective_trip_logic DUT (.clock_in(clock_in), .resetn_in(resetn_in),
		.trip_output_block_in(req.block), .single_phase_request_in(req.single),
		.three_phase_request_in(req.three), .phase_a_start_in(req.start.a),
		.phase_b_start_in(req.start.b), .phase_c_start_in(req.start.c),
		.force_all_phases_in(req.force_all), .phase_a_trip_out(pa),
		.phase_b_trip_out(pb), .phase_c_trip_out(pc), .any_trip_out(any),
		.all_phase_trip_out(all), .irq_out(irq), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task automatic end_of_test();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	// pready is never assumed: the access phase waits for it under a bound
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		int n;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clock_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			failures++;
			end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// three edges: through the source model, the trip register and one spare edge, then settle
	task automatic drive(input logic [1:0] k, input logic [2:0] f, input logic b, input logic fo);
		@(posedge clock_in);
		kind <= k;
		fault <= f;
		blk <= b;
		frc <= fo;
		repeat (3) @(posedge clock_in);
		#1;
	endtask

	task automatic restart(input logic [1:0] mode);
		@(posedge clock_in);
		resetn_in <= 1'b0;
		kind <= 2'h0;
		blk <= 1'b0;
		frc <= 1'b0;
		repeat (5) @(posedge clock_in);
		resetn_in <= 1'b1;
		// off is left to the reset value so that the default itself is exercised
		if (mode != trip_logic_pkg::MODE_OFF) begin
			apb(1'b1, trip_logic_pkg::ADDR_MODE, {30'h0, mode});
		end
	endtask

	task automatic reset_values();
		restart(trip_logic_pkg::MODE_OFF);
		apb(1'b0, trip_logic_pkg::ADDR_PULSE, 32'h0);
		check(rd, {16'h0, trip_logic_pkg::PULSE_MS_DEFAULT}, "pulse default");
		apb(1'b0, trip_logic_pkg::ADDR_EVOLVE, 32'h0);
		check(rd, {16'h0, trip_logic_pkg::EVOLVE_MS_DEFAULT}, "evolve default");
		apb(1'b1, trip_logic_pkg::ADDR_PULSE, 32'h00000014);
		apb(1'b0, trip_logic_pkg::ADDR_PULSE, 32'h0);
		check(rd, {16'h0, trip_logic_pkg::TIME_MS_MIN}, "pulse floor");
		apb(1'b1, trip_logic_pkg::ADDR_EVOLVE, 32'h0000FFFF);
		apb(1'b0, trip_logic_pkg::ADDR_EVOLVE, 32'h0);
		check(rd, {16'h0, trip_logic_pkg::TIME_MS_MAX}, "evolve ceiling");
		apb(1'b0, 12'h018, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped read");
		apb(1'b1, trip_logic_pkg::ADDR_MODE, {30'h0, trip_logic_pkg::MODE_SELECT});
		apb(1'b1, trip_logic_pkg::ADDR_MODE, 32'h00000003);
		apb(1'b0, trip_logic_pkg::ADDR_MODE, 32'h0);
		check(rd, {30'h0, trip_logic_pkg::MODE_SELECT}, "mode code 3 ignored");
		restart(trip_logic_pkg::MODE_OFF);
		apb(1'b0, trip_logic_pkg::ADDR_MODE, 32'h0);
		check(rd, {30'h0, trip_logic_pkg::MODE_OFF}, "mode default");
		apb(1'b0, trip_logic_pkg::ADDR_PULSE, 32'h0);
		check(rd, {16'h0, trip_logic_pkg::PULSE_MS_DEFAULT}, "pulse default again");
	endtask

	task automatic trip_case(input logic [1:0] mode, input logic [1:0] k, input logic [2:0] f,
		input logic fo, input logic [4:0] exp);
		restart(mode);
		drive(k, f, 1'b0, fo);
		check({27'h0, trips}, {27'h0, exp}, "trip outputs");
	endtask

	task automatic stretch_block_irq();
		restart(trip_logic_pkg::MODE_SELECT);
		apb(1'b1, trip_logic_pkg::ADDR_MASK, 32'h00000001);
		drive(2'h1, 3'h4, 1'b0, 1'b0);
		check({31'h0, irq}, 32'h1, "irq on trip");
		drive(2'h0, 3'h0, 1'b0, 1'b0);
		repeat (1000) @(posedge clock_in);
		#1;
		check({27'h0, trips}, 32'h12, "pulse held");
		drive(2'h0, 3'h0, 1'b1, 1'b0);
		check({27'h0, trips}, 32'h0, "blocked");
		apb(1'b0, trip_logic_pkg::ADDR_IRQ, 32'h0);
		check(rd, 32'h1, "irq status before clear");
		apb(1'b1, trip_logic_pkg::ADDR_IRQ, 32'h00000007);
		#1;
		check({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'b0, trip_logic_pkg::ADDR_IRQ, 32'h0);
		check(rd, 32'h0, "irq status");
	endtask

	task automatic off_mid_trip();
		restart(trip_logic_pkg::MODE_SELECT);
		drive(2'h1, 3'h2, 1'b0, 1'b0);
		check({27'h0, trips}, 32'h0A, "phase b trip");
		check({31'h0, irq}, 32'h0, "masked irq");
		apb(1'b0, trip_logic_pkg::ADDR_STATUS, 32'h0);
		check(rd, 32'h0000000A, "status word");
		apb(1'b1, trip_logic_pkg::ADDR_MODE, {30'h0, trip_logic_pkg::MODE_OFF});
		repeat (2) @(posedge clock_in);
		#1;
		check({27'h0, trips}, 32'h0, "off clears");
	endtask

	initial begin
		reset_values();
		trip_case(trip_logic_pkg::MODE_OFF, 2'h1, 3'h4, 1'b0, 5'h00);
		trip_case(trip_logic_pkg::MODE_SELECT, 2'h1, 3'h4, 1'b0, 5'h12);
		trip_case(trip_logic_pkg::MODE_SELECT, 2'h1, 3'h6, 1'b0, 5'h1F);
		trip_case(trip_logic_pkg::MODE_SELECT, 2'h1, 3'h1, 1'b1, 5'h1F);
		trip_case(trip_logic_pkg::MODE_THREE, 2'h1, 3'h2, 1'b0, 5'h1F);
		trip_case(trip_logic_pkg::MODE_SELECT, 2'h2, 3'h0, 1'b0, 5'h1F);
		stretch_block_irq();
		off_mid_trip();
		end_of_test();
	end
endmodule
